// ==== hdl/dfc_top.v ====
`timescale 1ns/1ps
`include "dfc_consts.vh"
module dfc_top #(
	parameter NCH = 8,
	parameter IW  = 3,
	parameter CW  = 16
) (
	input  wire                    sys_clk,    // 40 MHz clock
	input  wire                    sys_rst,    // Synchronous reset, high
	// AHB-Lite register slave
	input  wire                    hsel,       // Slave select
	input  wire [31:0]             haddr,      // Address
	input  wire [1:0]              htrans,     // Transfer type
	input  wire                    hwrite,     // Write
	input  wire [2:0]              hsize,      // Size, word only
	input  wire [3:0]              hprot,      // Protection, bit 1 privileged
	input  wire [31:0]             hwdata,     // Write data
	input  wire                    hready,     // Bus ready
	output reg  [31:0]             hrdata,     // Read data
	output reg                     hreadyout,  // Ready except in reset
	output reg                     hresp,      // Always OKAY
	// Peripheral requests
	input  wire [`DFC_NUM_REQ-1:0] periph_req, // Request lines
	output reg  [`DFC_NUM_REQ-1:0] periph_ack, // One-cycle ack per line
	// Transfer master port
	output reg                     m_valid,    // Access request, held to m_ready
	output reg                     m_write,    // Access is a write
	output reg                     m_periph,   // Access targets peripheral side
	output reg  [31:0]             m_addr,     // Byte address
	output reg  [1:0]              m_size,     // 0 byte, 1 half, 2 word
	output reg  [31:0]             m_wdata,    // Write data
	input  wire [31:0]             m_rdata,    // Read data
	input  wire                    m_ready,    // Access done
	input  wire                    m_err,      // Error response
	// Interrupts
	output reg  [NCH-1:0]          ch_irq      // Level per channel
);

	// ****************************************
	// Channel state
	// ****************************************
	// Engine states; one read and one write beat per service
	localparam ST_IDLE = 2'd0;
	localparam ST_RD   = 2'd1;
	localparam ST_WR   = 2'd2;

	// Per-channel setup, live pointers and counts
	reg [31:0]    cfg   [0:NCH-1];
	reg [CW-1:0]  init  [0:NCH-1];
	reg [CW-1:0]  cnt   [0:NCH-1];
	reg [31:0]    pbase [0:NCH-1];
	reg [31:0]    mbase [0:NCH-1];
	reg [31:0]    pptr  [0:NCH-1];
	reg [31:0]    mptr  [0:NCH-1];
	// User level of the last config write with the enable bit clear on each channel while it was disabled
	reg [NCH-1:0] owner;
	reg [3*NCH-1:0] flags;

	// Bookkeeping for the channel in service
	reg [1:0]     state;
	reg [IW-1:0]  cur;
	reg [31:0]    dst_addr;
	reg [5:0]     cur_src;

	// Write address phase kept for its data phase
	reg           wr_pend;
	reg [7:0]     wr_addr;
	reg           wr_user;

	integer i;

	// ****************************************
	// Request routing and arbitration
	// ****************************************
	wire [6*NCH-1:0] sel_flat;
	wire [2*NCH-1:0] prio_flat;
	wire [NCH-1:0]   ch_req;
	wire [6*NCH-1:0] ch_src;
	reg  [NCH-1:0]   want;
	wire             arb_any;
	wire [IW-1:0]    arb_pick;

	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : g_flat
			assign sel_flat[6*g +: 6]  = cfg[g][`DFC_CFG_SEL];
			assign prio_flat[2*g +: 2] = cfg[g][`DFC_CFG_PRIO];
		end
	endgenerate

	// Copy channels need no request and so run back to back
	always @* begin
		for (i = 0; i < NCH; i = i + 1) begin
			want[i] = cfg[i][`DFC_CFG_ON] && (cnt[i] != {CW{1'b0}})
				&& (cfg[i][`DFC_CFG_COPY] || ch_req[i]);
		end
	end

	dfc_req_mux #(.NCH(NCH)) u_mux (
		.periph_req (periph_req),
		.sel        (sel_flat),
		.ch_req     (ch_req),
		.ch_src     (ch_src)
	);

	dfc_arbiter #(.NCH(NCH), .IW(IW)) u_arb (
		.want (want),
		.prio (prio_flat),
		.any  (arb_any),
		.pick (arb_pick)
	);

	// ****************************************
	// Transfer helpers
	// ****************************************
	wire [31:0]   c_cfg   = cfg[cur];
	wire          c_mfirst = c_cfg[`DFC_CFG_DIR] && !c_cfg[`DFC_CFG_COPY];
	wire [31:0]   a_cfg   = cfg[arb_pick];
	wire          a_mfirst = a_cfg[`DFC_CFG_DIR] && !a_cfg[`DFC_CFG_COPY];
	wire [31:0]   a_src   = a_mfirst ? mptr[arb_pick] : pptr[arb_pick];
	wire [31:0]   a_dst   = a_mfirst ? pptr[arb_pick] : mptr[arb_pick];
	// Both ends are checked so no beat ever reaches the reserved hole
	wire          a_rsv   = (a_src >= `DFC_RSV_LO && a_src < `DFC_RSV_HI)
		|| (a_dst >= `DFC_RSV_LO && a_dst < `DFC_RSV_HI);
	// Steps are applied only once a write beat finishes cleanly
	wire [31:0]   pstep   = c_cfg[`DFC_CFG_PSTEP] ? (32'h1 << c_cfg[`DFC_CFG_PSIZE]) : 32'h0;
	wire [31:0]   mstep   = c_cfg[`DFC_CFG_MSTEP] ? (32'h1 << c_cfg[`DFC_CFG_MSIZE]) : 32'h0;
	wire [CW-1:0] cnt_dec = cnt[cur] - {{(CW-1){1'b0}}, 1'b1};

	// ****************************************
	// Register bus decode
	// ****************************************
	// Zero wait states: writes land one cycle after the address phase
	wire          ahb_go  = hsel && htrans[1] && hready;
	wire [IW-1:0] wr_ch   = wr_addr[IW+3:4];
	wire          wr_isch = wr_addr < NCH * 16;
	wire [IW-1:0] rd_ch   = haddr[IW+3:4];
	wire          rd_isch = haddr[31:8] == 24'h0 && haddr[7:0] < NCH * 16;
	reg  [31:0]   rd_val;
	wire [31:0]   wr_cfg  = hwdata & `DFC_CFG_MASK;

	// Read mux; a read right after a write to the same register sees the old value
	always @* begin
		rd_val = 32'h0;
		if (rd_isch && haddr[3:0] == `DFC_OFS_CFG) begin
			rd_val = cfg[rd_ch];
		end else if (rd_isch && haddr[3:0] == `DFC_OFS_COUNT) begin
			rd_val = {{(32-CW){1'b0}}, cnt[rd_ch]};
		end else if (rd_isch && haddr[3:0] == `DFC_OFS_PBASE) begin
			rd_val = pbase[rd_ch];
		end else if (rd_isch && haddr[3:0] == `DFC_OFS_MBASE) begin
			rd_val = mbase[rd_ch];
		end else if (haddr == {24'h0, `DFC_ADDR_STATUS}) begin
			rd_val = {{(32-3*NCH){1'b0}}, flags};
		end
	end

	// ****************************************
	// Bus slave
	// ****************************************

	// Bus responses
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			hrdata    <= 32'h0;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h0;
			wr_user   <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend   <= ahb_go && hwrite && haddr[31:8] == 24'h0;
			wr_addr   <= haddr[7:0];
			wr_user   <= !hprot[1];
			if (ahb_go && !hwrite) begin
				hrdata <= rd_val;
			end
		end
	end

	// ****************************************
	// Channel registers and transfer engine
	// ****************************************
	// Hardware updates come after software writes so events win
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			for (i = 0; i < NCH; i = i + 1) begin
				cfg[i]   <= `DFC_CFG_RESET;
				init[i]  <= {CW{1'b0}};
				cnt[i]   <= {CW{1'b0}};
				pbase[i] <= 32'h0;
				mbase[i] <= 32'h0;
				pptr[i]  <= 32'h0;
				mptr[i]  <= 32'h0;
			end
			owner      <= {NCH{1'b0}};
			flags      <= {(3*NCH){1'b0}};
			state      <= ST_IDLE;
			cur        <= {IW{1'b0}};
			cur_src    <= 6'h3f;
			dst_addr   <= 32'h0;
			m_valid    <= 1'b0;
			m_write    <= 1'b0;
			m_periph   <= 1'b0;
			m_addr     <= 32'h0;
			m_size     <= 2'h0;
			m_wdata    <= 32'h0;
			periph_ack <= {`DFC_NUM_REQ{1'b0}};
			ch_irq     <= {NCH{1'b0}};
		end else begin
			periph_ack <= {`DFC_NUM_REQ{1'b0}};

			// ****************************************
			// Software writes
			// ****************************************

			// Clear first, so a same-cycle hardware set below wins
			if (wr_pend && wr_addr == `DFC_ADDR_CLEAR) begin
				flags <= flags & ~hwdata[3*NCH-1:0];
			end
			if (wr_pend && wr_isch && wr_addr[3:0] == `DFC_OFS_CFG) begin
				if (cfg[wr_ch][`DFC_CFG_ON]) begin
					cfg[wr_ch][`DFC_CFG_ON] <= wr_cfg[`DFC_CFG_ON];
				end else if (wr_cfg[`DFC_CFG_ON] && wr_user != owner[wr_ch]) begin
					flags[3*wr_ch + `DFC_FLG_FLT] <= 1'b1;
				end else begin
					cfg[wr_ch] <= wr_cfg;
					if (wr_cfg[`DFC_CFG_ON]) begin
						pptr[wr_ch] <= pbase[wr_ch];
						mptr[wr_ch] <= mbase[wr_ch];
					end else begin
						owner[wr_ch] <= wr_user;
					end
				end
			end
			// Count and bases only while disabled
			if (wr_pend && wr_isch && !cfg[wr_ch][`DFC_CFG_ON]) begin
				if (wr_addr[3:0] == `DFC_OFS_COUNT) begin
					init[wr_ch] <= hwdata[CW-1:0];
					cnt[wr_ch]  <= hwdata[CW-1:0];
				end else if (wr_addr[3:0] == `DFC_OFS_PBASE) begin
					pbase[wr_ch] <= hwdata;
					pptr[wr_ch]  <= hwdata;
				end else if (wr_addr[3:0] == `DFC_OFS_MBASE) begin
					mbase[wr_ch] <= hwdata;
					mptr[wr_ch]  <= hwdata;
				end
			end

			// ****************************************
			// Engine
			// ****************************************

			case (state)
				ST_IDLE: begin
					if (arb_any) begin
						cur     <= arb_pick;
						cur_src <= a_cfg[`DFC_CFG_COPY] ? 6'h3f : ch_src[6*arb_pick +: 6];
						if (a_rsv) begin
							flags[3*arb_pick + `DFC_FLG_FLT] <= 1'b1;
							cfg[arb_pick][`DFC_CFG_ON]       <= 1'b0;
						end else begin
							m_valid  <= 1'b1;
							m_write  <= 1'b0;
							m_periph <= !a_cfg[`DFC_CFG_COPY] && !a_mfirst;
							m_addr   <= a_src;
							m_size   <= a_mfirst ? a_cfg[`DFC_CFG_MSIZE] : a_cfg[`DFC_CFG_PSIZE];
							dst_addr <= a_dst;
							state    <= ST_RD;
						end
					end
				end
				ST_RD: begin
					if (m_ready) begin
						if (m_err) begin
							m_valid                     <= 1'b0;
							flags[3*cur + `DFC_FLG_FLT] <= 1'b1;
							cfg[cur][`DFC_CFG_ON]       <= 1'b0;
							state                       <= ST_IDLE;
						end else begin
							m_write  <= 1'b1;
							m_periph <= c_mfirst;
							m_addr   <= dst_addr;
							m_size   <= c_mfirst ? c_cfg[`DFC_CFG_PSIZE] : c_cfg[`DFC_CFG_MSIZE];
							m_wdata  <= m_rdata;
							state    <= ST_WR;
						end
					end
				end
				ST_WR: begin
					if (m_ready) begin
						m_valid <= 1'b0;
						m_write <= 1'b0;
						state   <= ST_IDLE;
						if (cur_src < `DFC_NUM_REQ) begin
							periph_ack[cur_src] <= 1'b1;
						end
						if (m_err) begin
							flags[3*cur + `DFC_FLG_FLT] <= 1'b1;
							cfg[cur][`DFC_CFG_ON]       <= 1'b0;
						end else begin
							pptr[cur] <= pptr[cur] + pstep;
							mptr[cur] <= mptr[cur] + mstep;
							cnt[cur]  <= cnt_dec;
							if (cnt_dec == (init[cur] >> 1)) begin
								flags[3*cur + `DFC_FLG_HALF] <= 1'b1;
							end
							if (cnt_dec == {CW{1'b0}}) begin
								flags[3*cur + `DFC_FLG_CPL] <= 1'b1;
								if (c_cfg[`DFC_CFG_WRAP]) begin
									cnt[cur]  <= init[cur];
									pptr[cur] <= pbase[cur];
									mptr[cur] <= mbase[cur];
								end else begin
									cfg[cur][`DFC_CFG_ON] <= 1'b0;
								end
							end
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase

			// ****************************************
			// Interrupts
			// ****************************************

			// Level interrupt per channel, one cycle behind its flags
			for (i = 0; i < NCH; i = i + 1) begin
				ch_irq[i] <= (flags[3*i + `DFC_FLG_CPL] && cfg[i][`DFC_CFG_CPL_IE])
					|| (flags[3*i + `DFC_FLG_HALF] && cfg[i][`DFC_CFG_HALF_IE])
					|| (flags[3*i + `DFC_FLG_FLT] && cfg[i][`DFC_CFG_FLT_IE]);
			end
		end
	end

endmodule

// ==== hdl/dfc_consts.vh ====
`ifndef DFC_CONSTS_VH
`define DFC_CONSTS_VH

// ****************************************
// Register map
// ****************************************
`define DFC_CH_STRIDE     8'h10
`define DFC_OFS_CFG       4'h0
`define DFC_OFS_COUNT     4'h4
`define DFC_OFS_PBASE     4'h8
`define DFC_OFS_MBASE     4'hc
`define DFC_ADDR_STATUS   8'h80
`define DFC_ADDR_CLEAR    8'h84

// ****************************************
// Configuration fields
// ****************************************
`define DFC_CFG_ON        0
`define DFC_CFG_CPL_IE    1
`define DFC_CFG_HALF_IE   2
`define DFC_CFG_FLT_IE    3
`define DFC_CFG_DIR       4
`define DFC_CFG_WRAP      5
`define DFC_CFG_PSTEP     6
`define DFC_CFG_MSTEP     7
`define DFC_CFG_PSIZE     9:8
`define DFC_CFG_MSIZE     11:10
`define DFC_CFG_PRIO      13:12
`define DFC_CFG_COPY      14
`define DFC_CFG_SEL       21:16
`define DFC_CFG_MASK      32'h003f_7fff
`define DFC_CFG_RESET     32'h0000_0000

// Status bits per channel, three per channel
`define DFC_FLG_CPL       0
`define DFC_FLG_HALF      1
`define DFC_FLG_FLT       2

// ****************************************
// Request sources and reserved region
// ****************************************
`define DFC_NUM_REQ       35
`define DFC_RSV_LO        32'h5000_0000
`define DFC_RSV_HI        32'h6000_0000

`endif

// ==== hdl/dfc_req_mux.v ====
`timescale 1ns/1ps
`include "dfc_consts.vh"
module dfc_req_mux #(
	parameter NCH = 8
) (
	input  wire [`DFC_NUM_REQ-1:0] periph_req, // Raw request lines
	input  wire [6*NCH-1:0]        sel,        // Select code per channel
	output wire [NCH-1:0]          ch_req,     // Routed request per channel
	output wire [6*NCH-1:0]        ch_src      // Line index per channel, 63 if none
);

	// ****************************************
	// Code to line index
	// ****************************************
	// Reserved codes give 63 so they never see a request
	function [5:0] code_to_line;
		input [5:0] code;
		begin
			if (code <= 6'h06) begin
				code_to_line = code;
			end else if (code >= 6'h0d && code <= 6'h10) begin
				code_to_line = code - 6'h06;
			end else if (code >= 6'h13 && code <= 6'h29) begin
				code_to_line = code - 6'h08;
			end else if (code == 6'h2e) begin
				code_to_line = 6'h22;
			end else begin
				code_to_line = 6'h3f;
			end
		end
	endfunction

	// One selector per channel
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : g_ch
			wire [5:0] line = code_to_line(sel[6*g +: 6]);
			assign ch_src[6*g +: 6] = line;
			assign ch_req[g] = (line < `DFC_NUM_REQ) ? periph_req[line] : 1'b0;
		end
	endgenerate

endmodule

// ==== hdl/dfc_arbiter.v ====
`timescale 1ns/1ps
module dfc_arbiter #(
	parameter NCH = 8,
	parameter IW  = 3
) (
	input  wire [NCH-1:0]   want, // Channels ready for service
	input  wire [2*NCH-1:0] prio, // Priority per channel
	output reg              any,  // Some channel wants service
	output reg  [IW-1:0]    pick  // Winning channel
);

	integer   i;
	reg [1:0] best;

	// Highest value wins; scanning upward with strict compare keeps ties low
	always @* begin
		any  = 1'b0;
		pick = {IW{1'b0}};
		best = 2'h0;
		for (i = 0; i < NCH; i = i + 1) begin
			if (want[i] && (!any || prio[2*i +: 2] > best)) begin
				any  = 1'b1;
				pick = i[IW-1:0];
				best = prio[2*i +: 2];
			end
		end
	end

endmodule

// ==== test/dfc_top_monitor.sv ====
`timescale 1ns/1ps
`include "dfc_consts.vh"
// ******
// Master port checker
// ******
module dfc_top_monitor (
	input wire        sys_clk,   // Clock
	input wire        sys_rst,   // Reset
	input wire        m_valid,   // Beat request
	input wire        m_write,   // Write beat
	input wire [31:0] m_addr,    // Address
	input wire [1:0]  m_size,    // Size
	input wire [31:0] m_wdata,   // Write data
	input wire [31:0] m_rdata,   // Read data
	input wire        m_ready,   // Beat done
	input wire        m_err,     // Error answer
	input wire [34:0] periph_ack // Acks
);
	// Finished beats
	wire rd_ok = m_valid && m_ready && !m_write && !m_err;
	wire wr_ok = m_valid && m_ready && m_write;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// One read then one write per service, held until answered
	a_beat_held: assert property (m_valid && !m_ready |=> m_valid && $stable(m_addr) && $stable(m_write))
		else $error("beat changed before ready");
	a_read_first: assert property ($rose(m_valid) |-> !m_write)
		else $error("service did not start with a read");
	a_data_moved: assert property (rd_ok |=> m_valid && m_write && m_wdata == $past(m_rdata))
		else $error("write beat lost the read data");
	a_one_pair: assert property (wr_ok |=> !m_valid)
		else $error("no idle after write beat");
	a_err_halts: assert property (m_valid && m_ready && m_err |=> !m_valid)
		else $error("beat continued after error");
	// Ack only after a finished write, on one line
	a_ack_cause: assert property (|periph_ack |-> $past(wr_ok))
		else $error("ack without finished write");
	a_ack_single: assert property ($onehot0(periph_ack))
		else $error("more than one ack line");
	// Reserved region is never reached
	a_no_reserved: assert property (m_valid |-> m_addr < `DFC_RSV_LO || m_addr >= `DFC_RSV_HI)
		else $error("beat in reserved region");
	a_size_legal: assert property (m_valid |-> m_size != 2'h3)
		else $error("illegal beat size");
	c_write: cover property (wr_ok);
	c_error: cover property (m_valid && m_ready && m_err);
	c_ack: cover property (|periph_ack);
endmodule
bind dfc_top dfc_top_monitor mon_u (
	.sys_clk, .sys_rst, .m_valid, .m_write, .m_addr, .m_size, .m_wdata, .m_rdata, .m_ready, .m_err, .periph_ack
);

// ==== test/dfc_mem_model.sv ====
`timescale 1ns/1ps
// ******
// Memory and peripheral side
// ******
module dfc_mem_model (
	input  wire        sys_clk,     // Clock
	input  wire        sys_rst,     // Reset
	input  wire        m_valid,     // Beat request
	input  wire        m_write,     // Write beat
	input  wire [31:0] m_addr,      // Address
	input  wire [31:0] m_wdata,     // Write data
	input  wire [3:0]  wait_cycles, // Answer delay
	input  wire [31:0] err_addr,    // Address answered with error
	output reg  [31:0] m_rdata,     // Read data
	output reg         m_ready,     // Beat done
	output reg         m_err        // Error answer
);
	reg [31:0] mem [0:255];
	reg [3:0]  cnt;
	// Known pattern so every word is predictable
	initial begin
		m_rdata = 32'h0;
		m_ready = 1'b0;
		m_err = 1'b0;
		for (int i = 0; i < 256; i++) begin
			mem[i] = 32'hc0de_0000 + i;
		end
	end
	// One-cycle answer after the delay; data scrambled unless a read is answered
	always @(posedge sys_clk) begin
		m_ready <= 1'b0;
		m_err <= 1'b0;
		m_rdata <= ~m_rdata;
		if (sys_rst || !m_valid || m_ready) begin
			cnt <= 4'h0;
		end else if (cnt != wait_cycles) begin
			cnt <= cnt + 4'h1;
		end else begin
			m_ready <= 1'b1;
			m_err <= (m_addr == err_addr);
			if (m_write) begin
				mem[m_addr[9:2]] <= m_wdata;
			end else begin
				m_rdata <= mem[m_addr[9:2]];
			end
		end
	end
endmodule

// ==== test/dma_channel_flow_control_tb.sv ====
`timescale 1ns/1ps
`include "dfc_consts.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module dma_channel_flow_control_tb;
	typedef struct {logic [31:0] cfg, pb, mb; int line, s0, s1, d0, d1; logic irq;} dfc_row_t;
	// ******
	// Signals and instances
	// ******
	logic        sys_clk = 0, sys_rst = 1, hsel = 0, hwrite = 0;
	logic [1:0]  htrans = 0;
	logic [3:0]  hprot = 0, wait_cycles = 0;
	logic [31:0] haddr = 0, hwdata = 0, err_addr = '1, rd;
	logic [34:0] periph_req = 0, req_arm = 0;
	wire         hreadyout, hresp, m_valid, m_write, m_periph, m_ready, m_err;
	wire [1:0]   m_size;
	wire [31:0]  hrdata, m_addr, m_wdata, m_rdata;
	wire [34:0]  periph_ack;
	wire [7:0]   ch_irq;
	int          fails = 0, n_compared = 0;
	logic        last_wside = 0;
	dfc_row_t    rows [4];
	dfc_top dut_u (
		.sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hprot, .hwdata, .hready(hreadyout),
		.hrdata, .hreadyout, .hresp, .periph_req, .periph_ack, .m_valid, .m_write, .m_periph, .m_addr, .m_size,
		.m_wdata, .m_rdata, .m_ready, .m_err, .ch_irq
	);
	dfc_mem_model mem_u (
		.sys_clk, .sys_rst, .m_valid, .m_write, .m_addr, .m_wdata, .wait_cycles, .err_addr, .m_rdata, .m_ready,
		.m_err
	);
	// Clock; a peripheral drops its request for a cycle after each ack
	initial forever #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) periph_req <= req_arm & ~periph_ack;
	// Side of the last finished write beat, peripheral when high
	always @(posedge sys_clk) if (m_valid && m_ready && m_write) last_wside <= m_periph;
	// Watchdog, well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		report_and_stop();
	end
	// ******
	// Bus tasks
	// ******
	task automatic ahb(input logic w, input logic [31:0] a, d, input logic p, output logic [31:0] q);
		int k = 0;
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		hprot <= {2'b00, p, 1'b1};
		do @(posedge sys_clk); while (hreadyout !== 1'b1 && ++k < 99);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1 && ++k < 99);
		q = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, d);
		ahb(1'b1, a, d, 1'b1, rd);
	endtask
	task automatic rdchk(input logic [31:0] a, e);
		ahb(1'b0, a, 32'h0, 1'b1, rd);
		`CHK(rd, e)
	endtask
	// Polls status; bounded so a missing flag cannot hang the run
	task automatic wait_flag(input int b);
		int k = 0;
		do ahb(1'b0, `DFC_ADDR_STATUS, 32'h0, 1'b1, rd); while (rd[b] !== 1'b1 && ++k < 200);
		`CHK(rd[b], 1'b1)
	endtask
	function automatic logic [31:0] pat(input int i);
		return 32'hc0de_0000 + i;
	endfunction
	task report_and_stop;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ******
	// Tests
	// ******
	initial begin
		// Directions: periph to mem, mem to periph, copy, byte-stepped periph
		rows[0] = '{32'h0001_0a82, 32'h4000_0200, 32'h2000_0040, 1, 'h80, 'h80, 'h10, 'h11, 1'b1};
		rows[1] = '{32'h000e_3a90, 32'h4000_0204, 32'h2000_0080, 8, 'h21, 'h21, 'h81, 'h81, 1'b0};
		rows[2] = '{32'h002f_4ac4, 32'h2000_00c0, 32'h2000_00e0, -1, 'h30, 'h31, 'h38, 'h39, 1'b1};
		rows[3] = '{32'h002e_08c8, 32'h4000_0280, 32'h2000_0120, 34, 'ha0, 'ha0, 'h48, 'h49, 1'b0};
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		for (int r = 0; r < 4; r++) begin
			wait_cycles <= 4'(r);
			wr(32'h04, 32'h2);
			wr(32'h08, rows[r].pb);
			wr(32'h0c, rows[r].mb);
			wr(32'h00, rows[r].cfg);
			wr(`DFC_ADDR_CLEAR, 32'h7);
			wr(32'h00, rows[r].cfg | 32'h1);
			if (rows[r].line >= 0) req_arm[rows[r].line] <= 1'b1;
			wait_flag(0);
			req_arm <= '0;
			repeat (2) @(posedge sys_clk);
			`CHK(mem_u.mem[rows[r].d0], pat(rows[r].s0))
			`CHK(mem_u.mem[rows[r].d1], pat(rows[r].s1))
			`CHK(ch_irq[0], rows[r].irq)
			`CHK(last_wside, (r == 1))
			`CHK(hresp, 1'b0)
			rdchk(`DFC_ADDR_STATUS, 32'h3);
			rdchk(32'h04, 32'h0);
			wr(`DFC_ADDR_CLEAR, 32'h7);
			rdchk(`DFC_ADDR_STATUS, 32'h0);
			`CHK(ch_irq[0], 1'b0)
			wr(32'h00, 32'h0);
			$display("direction row %0d done", r);
		end
		// Live channel keeps its setup; only the enable bit can change
		wr(32'h14, 32'h5);
		wr(32'h18, 32'h4000_0300);
		wr(32'h10, 32'h0002_0a81);
		wr(32'h14, 32'h9);
		wr(32'h18, 32'h4000_0000);
		wr(32'h10, 32'h0002_3a81);
		rdchk(32'h14, 32'h5);
		rdchk(32'h18, 32'h4000_0300);
		rdchk(32'h10, 32'h0002_0a81);
		wr(32'h10, 32'h0002_0a80);
		rdchk(32'h10, 32'h0002_0a80);
		$display("locked setup done");
		// Circular copy keeps going and rewinds both pointers
		wr(32'h24, 32'h2);
		wr(32'h28, 32'h2000_0140);
		wr(32'h2c, 32'h2000_0160);
		wr(32'h20, 32'h002f_4ae1);
		wait_flag(6);
		wr(`DFC_ADDR_CLEAR, 32'h1c0);
		wait_flag(6);
		`CHK(mem_u.mem['h59], pat('h51))
		`CHK(mem_u.mem['h5a], pat('h5a))
		wr(32'h20, 32'h002f_4ae0);
		wr(32'h20, 32'h002f_4ac0);
		rdchk(32'h20, 32'h002f_4ac0);
		$display("circular done");
		// Reserved region and bus error each stop a channel; a foreign enabler is refused
		wr(32'h34, 32'h1);
		wr(32'h38, 32'h5000_0010);
		wr(32'h30, 32'h002f_4a09);
		wait_flag(11);
		rdchk(32'h30, 32'h002f_4a08);
		`CHK(ch_irq[3], 1'b1)
		err_addr <= 32'h2000_01c0;
		wr(32'h44, 32'h2);
		wr(32'h48, 32'h2000_01c0);
		wr(32'h4c, 32'h2000_01e0);
		wr(32'h40, 32'h002f_4a01);
		wait_flag(14);
		rdchk(32'h44, 32'h2);
		rdchk(32'h40, 32'h002f_4a00);
		`CHK(ch_irq[4], 1'b0)
		wr(32'h54, 32'h1);
		wr(32'h50, 32'h002f_4a00);
		ahb(1'b1, 32'h50, 32'h002f_4a01, 1'b0, rd);
		wait_flag(17);
		rdchk(32'h50, 32'h002f_4a00);
		wr(32'h90, 32'hffff_ffff);
		rdchk(32'h90, 32'h0);
		$display("fault cases done");
		// Reset with all channels disabled wipes setup and flags
		sys_rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		rdchk(32'h30, 32'h0);
		rdchk(`DFC_ADDR_STATUS, 32'h0);
		$display("reset done");
		report_and_stop();
	end
endmodule
